// [common/usfl_pkg.sv]
// Constants and types of the serial status flag block
// Notes on behaviour
// - Loading received character sets buffer-full flag
// - Seen buffer-full flag clears on buffer read
// - Flag set after status read survives read
// - Busy clears when frame ends, buffer empty
// - Restart sets busy and raises transmit interrupt
// - Move into shifter clears full, raises interrupt
// - Software write sets transmit-buffer-full flag
// - Infrared pulse lasts three sixteenths bit period
// - Overrun sets flag, interrupt only if flag was clear, discards new character
// - Error flags clear like buffer-full flag
package usfl_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned STATUS_W    = 8;

  // Bit positions in line_status_register
  localparam int unsigned ST_RX_BUFFER_FULL_FLAG_POS = 0;
  localparam int unsigned ST_OVERRUN_ERROR_FLAG_POS = 1;
  localparam int unsigned ST_FRAMING_ERROR_FLAG_POS = 2;
  localparam int unsigned ST_PARITY_ERROR_FLAG_POS = 3;
  localparam int unsigned ST_TX_BUFFER_FULL_FLAG_POS = 4;
  localparam int unsigned ST_TX_BUSY_FLAG_POS = 5;

  // Reset values
  localparam logic              FLAG_RST   = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RST   = 8'h00;

  // Timing in receive_timing_clock ticks
  localparam int unsigned RT_PER_BIT  = 16;
  localparam int unsigned IR_PULSE_RT = 3;
  localparam int unsigned RT_CNT_W    = 5;
  localparam int unsigned FRAME_BITS  = 10;
  localparam int unsigned BIT_CNT_W   = 4;

  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } usfl_tx_state_type;

endpackage : usfl_pkg

// [hdl/usfl_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module usfl_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty
  assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty     = (wr_ptr_q == rd_ptr_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

endmodule : usfl_fifo

// [hdl/usfl_status.sv]
// Serial port status flags, holding buffers and transmit shifter
`timescale 1ns/100ps
module usfl_status
  import usfl_pkg::*;
#(
  parameter int unsigned RT_BIT   = RT_PER_BIT,
  parameter int unsigned IR_PULSE = IR_PULSE_RT,
  parameter int unsigned DEPTH    = FIFO_DEPTH
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                status_read,
  output logic      [STATUS_W-1:0] line_status_register,
  input  wire logic                rx_buf_read,
  output logic      [DATA_W-1:0]   receive_holding_buffer,
  input  wire logic                tx_buf_write,
  input  wire logic [DATA_W-1:0]   tx_write_data,
  input  wire logic                tx_enable,
  input  wire logic                irda_mode,
  input  wire logic                rt_tick,
  input  wire logic                rx_char_valid,
  output logic                     rx_char_ready,
  input  wire logic [DATA_W-1:0]   rx_char_data,
  input  wire logic                rx_char_parity_err,
  input  wire logic                rx_char_framing_err,
  output logic                     txd,
  output logic                     tx_interrupt_request,
  output logic                     rx_interrupt_request
);

  localparam int unsigned ENTRY_W = DATA_W + 2;

  // Receive side state
  logic [DATA_W-1:0]  rhb_q;
  logic               rx_buffer_full_flag_q;
  logic               overrun_error_flag_q;
  logic               framing_error_flag_q;
  logic               parity_error_flag_q;
  logic               rx_buffer_full_flag_seen_q;
  logic               overrun_error_flag_seen_q;
  logic               framing_error_flag_seen_q;
  logic               parity_error_flag_seen_q;
  logic               rx_irq_q;

  // Receive FIFO wiring
  logic [ENTRY_W-1:0] fifo_in;
  logic [ENTRY_W-1:0] fifo_out;
  logic               fifo_out_valid;
  logic               rx_load;
  logic               overrun;

  // Transmit side state
  logic [DATA_W-1:0]     thr_q;
  logic                  tx_buffer_full_flag_q;
  usfl_tx_state_type     tx_state_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [RT_CNT_W-1:0]   rt_cnt_q;
  logic [BIT_CNT_W-1:0]  bit_cnt_q;
  logic                  txd_q;
  logic                  tx_irq_q;
  logic                  bit_end;
  logic                  frame_end;
  logic                  tx_load;
  logic                  tx_busy;
  logic                  ir_window;

  // ------------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------------

  // Deeper buffer before the holding register; receiver sees ready
  assign fifo_in = {rx_char_framing_err, rx_char_parity_err, rx_char_data};

  usfl_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (rx_char_valid),
    .in_ready  (rx_char_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (rx_load),
    .out_data  (fifo_out)
  );

  assign rx_load = fifo_out_valid && !rx_buffer_full_flag_q;

  assign overrun = rx_char_valid && !rx_char_ready;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rhb_q <= DATA_RST;
    end else if (rx_load) begin
      rhb_q <= fifo_out[DATA_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_buffer_full_flag_q <= FLAG_RST;
    end else if (rx_load) begin
      rx_buffer_full_flag_q <= 1'b1;
    end else if (rx_buf_read && rx_buffer_full_flag_seen_q) begin
      rx_buffer_full_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      overrun_error_flag_q <= FLAG_RST;
    end else if (overrun) begin
      overrun_error_flag_q <= 1'b1;
    end else if (rx_buf_read && overrun_error_flag_seen_q) begin
      overrun_error_flag_q <= 1'b0;
    end
  end

  // Errors belong to the character entering the holding buffer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      framing_error_flag_q <= FLAG_RST;
    end else if (rx_load && fifo_out[DATA_W+1]) begin
      framing_error_flag_q <= 1'b1;
    end else if (rx_buf_read && framing_error_flag_seen_q) begin
      framing_error_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      parity_error_flag_q <= FLAG_RST;
    end else if (rx_load && fifo_out[DATA_W]) begin
      parity_error_flag_q <= 1'b1;
    end else if (rx_buf_read && parity_error_flag_seen_q) begin
      parity_error_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_buffer_full_flag_seen_q <= 1'b0;
      overrun_error_flag_seen_q <= 1'b0;
      framing_error_flag_seen_q <= 1'b0;
      parity_error_flag_seen_q <= 1'b0;
    end else if (status_read) begin
      rx_buffer_full_flag_seen_q <= rx_buffer_full_flag_q;
      overrun_error_flag_seen_q <= overrun_error_flag_q;
      framing_error_flag_seen_q <= framing_error_flag_q;
      parity_error_flag_seen_q <= parity_error_flag_q;
    end else if (rx_buf_read) begin
      // A second buffer read needs a fresh status read
      rx_buffer_full_flag_seen_q <= 1'b0;
      overrun_error_flag_seen_q <= 1'b0;
      framing_error_flag_seen_q <= 1'b0;
      parity_error_flag_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= rx_load || (overrun && !overrun_error_flag_q);
    end
  end

  // ------------------------------------------------------------------
  // Transmit path
  // ------------------------------------------------------------------

  assign tx_busy   = (tx_state_q == TX_SHIFT);
  assign bit_end   = tx_busy && rt_tick && (rt_cnt_q == RT_CNT_W'(RT_BIT - 1));
  assign frame_end = bit_end && (bit_cnt_q == BIT_CNT_W'(FRAME_BITS - 1));

  // Buffer moves into shifter
  // Idle start waits for a tick, else start bit and pulse come short
  assign tx_load = tx_buffer_full_flag_q && tx_enable && (tx_busy ? frame_end : rt_tick);

  // Later writes overwrite data not yet moved to the shifter
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      thr_q <= DATA_RST;
    end else if (tx_buf_write) begin
      thr_q <= tx_write_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_buffer_full_flag_q <= FLAG_RST;
    end else if (tx_buf_write) begin
      tx_buffer_full_flag_q <= 1'b1;
    end else if (tx_load) begin
      tx_buffer_full_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_state_q <= TX_IDLE;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_load) begin
            tx_state_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (frame_end && !tx_load) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Frame is start, data LSB first, one stop bit
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shift_q <= '1;
    end else if (tx_load) begin
      shift_q <= {1'b1, thr_q, 1'b0};
    end else if (bit_end) begin
      shift_q <= {1'b1, shift_q[FRAME_BITS-1:1]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rt_cnt_q <= '0;
    end else if (tx_load || bit_end) begin
      rt_cnt_q <= '0;
    end else if (tx_busy && rt_tick) begin
      rt_cnt_q <= rt_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bit_cnt_q <= '0;
    end else if (tx_load) begin
      bit_cnt_q <= '0;
    end else if (bit_end) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  assign ir_window = (rt_cnt_q < RT_CNT_W'(IR_PULSE));

  // Idle line is high in plain mode, low in infrared mode
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txd_q <= 1'b1;
    end else if (irda_mode) begin
      txd_q <= tx_busy && !shift_q[0] && ir_window;
    end else begin
      txd_q <= tx_busy ? shift_q[0] : 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= tx_load;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------

  always_comb begin
    line_status_register              = '0;
    line_status_register[ST_RX_BUFFER_FULL_FLAG_POS] = rx_buffer_full_flag_q;
    line_status_register[ST_OVERRUN_ERROR_FLAG_POS] = overrun_error_flag_q;
    line_status_register[ST_FRAMING_ERROR_FLAG_POS] = framing_error_flag_q;
    line_status_register[ST_PARITY_ERROR_FLAG_POS] = parity_error_flag_q;
    line_status_register[ST_TX_BUFFER_FULL_FLAG_POS] = tx_buffer_full_flag_q;
    line_status_register[ST_TX_BUSY_FLAG_POS] = tx_busy;
  end

  assign receive_holding_buffer = rhb_q;
  assign txd                    = txd_q;
  assign tx_interrupt_request   = tx_irq_q;
  assign rx_interrupt_request   = rx_irq_q;

endmodule : usfl_status

// [test/usfl_status_assertions.sv]
// Port checks of the serial status flag block
`timescale 1ns/100ps
module usfl_status_checker
  import usfl_pkg::*;
#(parameter int unsigned RT_BIT = RT_PER_BIT, parameter int unsigned IR_PULSE = IR_PULSE_RT,
  parameter int unsigned DEPTH = FIFO_DEPTH) (
  input wire logic                sys_clk,
  input wire logic                reset,
  input wire logic                status_read,
  input wire logic [STATUS_W-1:0] line_status_register,
  input wire logic                rx_buf_read,
  input wire logic                tx_buf_write,
  input wire logic                rx_char_valid,
  input wire logic                rx_char_ready,
  input wire logic                tx_interrupt_request,
  input wire logic                rx_interrupt_request
);
  logic [STATUS_W-1:0] lsr;
  logic [3:0]          seen_q;
  assign lsr = line_status_register;
  // Snapshot of flags seen by the last status read
  always_ff @(posedge sys_clk) begin
    if (reset) seen_q <= 4'h0;
    else if (status_read) seen_q <= lsr[3:0];
    else if (rx_buf_read) seen_q <= 4'h0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_load_irq: assert property ($rose(lsr[0]) |-> rx_interrupt_request)
    else $error("load without rx irq");
  chk_seen_clear: assert property (rx_buf_read && !status_read && seen_q[0] |=> !lsr[0])
    else $error("seen full flag kept");
  chk_fresh_read: assert property ($fell(lsr[0]) |-> $past(rx_buf_read && seen_q[0]))
    else $error("full flag cleared unseen");
  chk_overrun_set: assert property (rx_char_valid && !rx_char_ready |=> lsr[1])
    else $error("overrun not flagged");
  chk_err_clear: assert property ($fell(lsr[1]) |-> $past(rx_buf_read && seen_q[1]))
    else $error("overrun cleared unseen");
  chk_write_full: assert property (tx_buf_write |=> lsr[4]) else $error("write left buffer empty");
  // Interrupt flop updates on the same edge as the move
  chk_move_irq: assert property ($fell(lsr[4]) |-> lsr[5] && tx_interrupt_request)
    else $error("move without busy or irq");
  chk_busy_irq: assert property ($rose(lsr[5]) |-> tx_interrupt_request)
    else $error("restart without irq");
  chk_busy_end: assert property ($fell(lsr[5]) |-> !$past(lsr[4])) else $error("busy dropped with data");
  chk_reset_zero: assert property ($fell(reset) |-> lsr == 8'h00) else $error("flags set after reset");
  cover property ($rose(lsr[1]));
  cover property ($fell(lsr[5]));
  cover property ($fell(lsr[0]));
  cover property ($rose(tx_interrupt_request));
endmodule : usfl_status_checker

bind usfl_status usfl_status_checker #(.RT_BIT(RT_BIT), .IR_PULSE(IR_PULSE), .DEPTH(DEPTH)) usfl_status_checker_inst (
  .sys_clk(sys_clk), .reset(reset), .status_read(status_read), .line_status_register(line_status_register),
  .rx_buf_read(rx_buf_read), .tx_buf_write(tx_buf_write), .rx_char_valid(rx_char_valid),
  .rx_char_ready(rx_char_ready), .tx_interrupt_request(tx_interrupt_request),
  .rx_interrupt_request(rx_interrupt_request));

// [test/usfl_remote.sv]
// Far side model: tick source, character source, line decoder
`timescale 1ns/100ps
module usfl_remote #(parameter int P = 4) (
  input wire logic  sys_clk,
  input wire logic  txd,
  input wire logic  irda_mode,
  output logic       rt_tick,
  output logic       rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic       rx_char_parity_err,
  output logic       rx_char_framing_err,
  output logic [7:0] got,
  output int         got_n
);
  int tc;
  int n;
  initial begin
    {tc, n, got_n, rt_tick, rx_char_valid, rx_char_parity_err, rx_char_framing_err} = '0;
    {rx_char_data, got} = '0;
  end
  always @(negedge sys_clk) begin
    tc <= (tc + 1) % P;
    rt_tick <= (tc == P - 1);
  end
  task automatic send(input logic [7:0] d, input logic pe, input logic fe);
    @(negedge sys_clk) {rx_char_valid, rx_char_data, rx_char_parity_err, rx_char_framing_err} = {1'b1, d, pe, fe};
    // Stale lines are inverted, not held
    @(negedge sys_clk) {rx_char_valid, rx_char_data, rx_char_parity_err, rx_char_framing_err} = {1'b0, ~d, ~pe, ~fe};
  endtask : send
  // Mid-bit sampling, plain line only
  always @(posedge sys_clk) if (rt_tick && !irda_mode) begin
    if (n == 0 && txd === 1'b0) n <= 1;
    else if (n > 0) begin
      n <= (n == 152) ? 0 : n + 1;
      if (n > 16 && n % 16 == 8 && n < 150) got <= {txd, got[7:1]};
      if (n == 152) got_n <= got_n + 1;
    end
  end
endmodule : usfl_remote

// [test/tb_usfl_status.sv]
// Self-checking bench of the serial status flag block
`timescale 1ns/100ps
module tb_usfl_status;
  localparam int P = 4;
  logic sys_clk, reset, status_read, rx_buf_read, tx_buf_write, tx_enable, irda_mode;
  logic rt_tick, rx_char_valid, rx_char_ready, pe, fe, txd, tx_irq, rx_irq;
  logic [7:0] tx_write_data, lsr, rhb, rx_char_data, got;
  int err_total, comparisons, tx_irqs, rx_irqs, got_n, w;
  usfl_status usfl_status_inst (.sys_clk(sys_clk), .reset(reset), .status_read(status_read),
    .line_status_register(lsr), .rx_buf_read(rx_buf_read), .receive_holding_buffer(rhb),
    .tx_buf_write(tx_buf_write), .tx_write_data(tx_write_data), .tx_enable(tx_enable), .irda_mode(irda_mode),
    .rt_tick(rt_tick), .rx_char_valid(rx_char_valid), .rx_char_ready(rx_char_ready), .rx_char_data(rx_char_data),
    .rx_char_parity_err(pe), .rx_char_framing_err(fe), .txd(txd), .tx_interrupt_request(tx_irq),
    .rx_interrupt_request(rx_irq));
  usfl_remote #(.P(P)) usfl_remote_inst (.sys_clk(sys_clk), .txd(txd), .irda_mode(irda_mode), .rt_tick(rt_tick),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .rx_char_parity_err(pe),
    .rx_char_framing_err(fe), .got(got), .got_n(got_n));
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (tx_irq === 1'b1) tx_irqs++;
  always @(posedge sys_clk) if (rx_irq === 1'b1) rx_irqs++;
  task conclude;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task cmp(input logic [7:0] a, input logic [7:0] e);
    comparisons++;
    if (a !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask : cmp
  task idle(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : idle
  task rd;
    @(negedge sys_clk) status_read = 1;
    @(negedge sys_clk) status_read = 0;
    idle(2);
    rx_buf_read = 1;
    @(negedge sys_clk) rx_buf_read = 0;
  endtask : rd
  task wr(input logic [7:0] d);
    @(negedge sys_clk) {tx_buf_write, tx_write_data} = {1'b1, d};
    @(negedge sys_clk) {tx_buf_write, tx_write_data} = {1'b0, ~d};
  endtask : wr
  task wt(input int k);
    w = 0;
    while (got_n < k) begin
      idle(1);
      if (++w > 3000) begin
        err_total++;
        $display("unexpected at %0t: no frame decoded", $time);
        conclude;
      end
    end
  endtask : wt
  // Bounded wait for a line level; w ends as the cycles spent
  task wait_txd(input logic v);
    w = 0;
    while (txd !== v) begin
      idle(1);
      if (++w > 3000) begin
        err_total++;
        $display("unexpected at %0t: txd stuck", $time);
        conclude;
      end
    end
  endtask : wait_txd
  initial begin
    {reset, status_read, rx_buf_read, tx_buf_write, tx_enable, irda_mode, tx_write_data} = {6'h20, 8'h00};
    idle(20);
    reset = 0;
    cmp(lsr, 8'h00);
    cmp({6'h00, txd, rx_char_ready}, 8'h03);
    usfl_remote_inst.send(8'hA5, 0, 0);
    idle(2);
    cmp(lsr, 8'h01);
    cmp(rhb, 8'hA5);
    rd;
    cmp(lsr, 8'h00);
    // Status read sees empty, parity char lands before buffer read
    @(negedge sys_clk) status_read = 1;
    @(negedge sys_clk) status_read = 0;
    usfl_remote_inst.send(8'h5A, 1, 0);
    idle(2);
    rx_buf_read = 1;
    @(negedge sys_clk) rx_buf_read = 0;
    cmp(lsr, 8'h09);
    rd;
    cmp(lsr, 8'h00);
    // Fill holding buffer and queue, tenth char refused
    for (int i = 0; i < 10; i++) begin
      if (i == 9) cmp({7'h00, rx_char_ready}, 8'h00);
      usfl_remote_inst.send(8'(i), i == 1, i == 2);
    end
    idle(1);
    cmp(lsr, 8'h03);
    for (int i = 0; i < 9; i++) begin
      cmp(rhb, 8'(i));
      cmp({4'h0, lsr[3:0]}, i == 0 ? 8'h03 : i == 1 ? 8'h09 : i == 2 ? 8'h05 : 8'h01);
      rd;
      idle(1);
    end
    cmp(lsr, 8'h00);
    // Eleven loads and one overrun, one request each
    cmp(8'(rx_irqs), 8'h0C);
    // Disabled transmitter keeps the data waiting
    wr(8'h3C);
    idle(3);
    cmp(lsr, 8'h10);
    tx_enable = 1;
    // Move from idle waits up to one tick period
    idle(P);
    cmp({6'h00, lsr[5:4]}, 8'h02);
    wr(8'hC3);
    cmp({6'h00, lsr[5:4]}, 8'h03);
    wt(1);
    cmp(got, 8'h3C);
    wt(2);
    cmp(got, 8'hC3);
    idle(60);
    cmp(lsr, 8'h00);
    cmp(8'(tx_irqs), 8'h02);
    irda_mode = 1;
    idle(2);
    wr(8'hFF);
    wait_txd(1'b1);
    wait_txd(1'b0);
    cmp(8'(w), 8'(3 * P));
    idle(700);
    cmp(lsr, 8'h00);
    cmp({7'h00, txd}, 8'h00);
    conclude;
  end
endmodule : tb_usfl_status
